// File: rtl/ssr_pkg.sv
// status byte / service request package: bit positions, masks, reset values, characters
// assumes every user sits on the single core clock
package ssr_pkg;
  localparam int unsigned ERR_BIT = 2;
  localparam int unsigned QSUM_BIT = 3;
  localparam int unsigned MSG_BIT = 4;
  localparam int unsigned EVT_BIT = 5;
  localparam int unsigned MASTER_BIT = 6;
  localparam int unsigned OPS_BIT = 7;
  localparam logic [7:0] SRE_WRITABLE = 8'hBC;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] STB_RESET = 8'h00;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_LF = 8'h0A;
  localparam logic [7:0] DEC_HUNDRED = 8'h64;
  localparam logic [7:0] DEC_TEN = 8'h0A;
endpackage

// File: rtl/ssr_fmt_if.sv
// carrier between the status block and its decimal response formatter
// assumes both ends on i_core_clk
`timescale 1ns/10ps
interface ssr_fmt_if;
  logic load;
  logic [7:0] value;
  logic talk;
  logic take;
  logic busy;
  logic [7:0] data;
  logic valid;
  modport ctl (output load, output value, output talk, output take, input busy, input data, input valid);
  modport fmt (input load, input value, input talk, input take, output busy, output data, output valid);
endinterface

// File: rtl/ssr_dec_fmt.sv
// one-entry response slot: holds a query result as decimal ascii text ended by line feed
// assumes talk and take come from the bus engine on the same clock
`timescale 1ns/10ps
module ssr_dec_fmt (
  input wire logic i_core_clk,
  input wire logic i_rst,
  ssr_fmt_if.fmt fmt
);
  typedef enum logic [0:0] {
    SSR_IDLE = 1'b0,
    SSR_SEND = 1'b1
  } ssr_fmt_state_e;

  typedef struct packed {
    ssr_fmt_state_e state;
    logic [3:0][7:0] chars;
    logic [2:0] count;
    logic [2:0] idx;
    logic [7:0] data;
    logic valid;
  } ssr_fmt_s;

  ssr_fmt_s cur;
  ssr_fmt_s next_cur;
  logic [7:0] hund;
  logic [7:0] tens;
  logic [7:0] units;

  always_comb begin
    next_cur = cur;
    hund = 8'(fmt.value / ssr_pkg::DEC_HUNDRED);
    tens = 8'((fmt.value / ssr_pkg::DEC_TEN) % ssr_pkg::DEC_TEN);
    units = 8'(fmt.value % ssr_pkg::DEC_TEN);
    unique case (cur.state)
      SSR_IDLE: begin
      end
      SSR_SEND: begin
        // a byte leaves only while the device is addressed to talk
        if (cur.valid && fmt.take) begin
          if (cur.idx == cur.count - 3'h1) begin
            next_cur.state = SSR_IDLE;
          end else begin
            next_cur.idx = cur.idx + 3'h1;
          end
        end
      end
    endcase
    // a new query replaces an unread answer; the slot holds only one
    if (fmt.load) begin
      next_cur.state = SSR_SEND;
      next_cur.idx = 3'h0;
      if (hund != 8'h00) begin
        next_cur.chars = {ssr_pkg::ASCII_LF, ssr_pkg::ASCII_ZERO + units, ssr_pkg::ASCII_ZERO + tens,
          ssr_pkg::ASCII_ZERO + hund};
        next_cur.count = 3'h4;
      end else if (tens != 8'h00) begin
        next_cur.chars = {8'h00, ssr_pkg::ASCII_LF, ssr_pkg::ASCII_ZERO + units, ssr_pkg::ASCII_ZERO + tens};
        next_cur.count = 3'h3;
      end else begin
        next_cur.chars = {8'h00, 8'h00, ssr_pkg::ASCII_LF, ssr_pkg::ASCII_ZERO + units};
        next_cur.count = 3'h2;
      end
    end
    next_cur.valid = (next_cur.state == SSR_SEND) && fmt.talk && !fmt.load;
    next_cur.data = next_cur.chars[next_cur.idx[1:0]];
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cur <= '{state: SSR_IDLE, chars: '0, count: 3'h0, idx: 3'h0, data: 8'h00, valid: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign fmt.busy = (cur.state == SSR_SEND);
  assign fmt.data = cur.data;
  assign fmt.valid = cur.valid;
endmodule

// File: rtl/ssr_status_top.sv
// status byte and service request logic of an ieee-488 instrument interface
// assumes summary flags, query strobes and talk handshake come from logic on i_core_clk
// Function
// - enable-mask query queues mask as decimal
// - status-byte query queues byte as decimal
// - result leaves only when addressed to talk
// - status query never clears any bit
// - summary bits follow their sources one clock later, not latched
// - bits from sources, bits 0,1 zero
// - bit 2 set when error queue nonempty
// - bit 3 set on questionable summary
// - bit 4 set when output queue nonempty
// - bit 5 set on enabled standard event
// - bit 7 set on enabled operation event
// - bit 6 set when any enabled condition
// - bit 6 rising asserts service request
// - request bit readable by serial poll
// - enable bit one lets bit request service
// - mask writable at bits 2,3,4,5,7 only
`timescale 1ns/10ps
module ssr_status_top (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_error_queue_nonempty,
  input wire logic i_questionable_summary,
  input wire logic i_output_queue_nonempty,
  input wire logic i_standard_event_summary,
  input wire logic i_operation_event_summary,
  input wire logic i_sre_write,
  input wire logic [7:0] i_sre_data,
  input wire logic i_sre_query,
  input wire logic i_stb_query,
  input wire logic i_talk_addressed,
  input wire logic i_byte_taken,
  input wire logic i_serial_poll,
  output logic [7:0] o_status_byte,
  output logic [7:0] o_poll_byte,
  output logic [7:0] o_sre_mask,
  output logic o_srq,
  output logic [7:0] o_talk_data,
  output logic o_talk_valid
);
  typedef struct packed {
    logic [7:0] service_request_enable_mask;
    logic [7:0] status_summary_byte;
    logic [7:0] poll_byte;
    logic master_summary_flag;
    logic request_service_flag;
    logic load;
    logic [7:0] value;
  } ssr_state_s;

  ssr_state_s cur;
  ssr_state_s next_cur;
  logic [7:0] live;
  logic summary_any;

  ssr_fmt_if fmt_bus ();

  ssr_dec_fmt u_fmt (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .fmt(fmt_bus)
  );

  always_comb begin
    next_cur = cur;
    // summary bits come from their sources and are registered; bit 4 also takes the slot's busy and bit 6 is computed here
    live = 8'h00;
    live[ssr_pkg::ERR_BIT] = i_error_queue_nonempty;
    live[ssr_pkg::QSUM_BIT] = i_questionable_summary;
    // an unread answer in our own slot is queue content too
    live[ssr_pkg::MSG_BIT] = i_output_queue_nonempty | fmt_bus.busy;
    live[ssr_pkg::EVT_BIT] = i_standard_event_summary;
    live[ssr_pkg::OPS_BIT] = i_operation_event_summary;
    summary_any = |(live & cur.service_request_enable_mask);
    live[ssr_pkg::MASTER_BIT] = summary_any;
    next_cur.status_summary_byte = live;
    next_cur.master_summary_flag = summary_any;
    if (i_sre_write) begin
      next_cur.service_request_enable_mask = i_sre_data & ssr_pkg::SRE_WRITABLE;
    end
    // request is raised on the rising summary; set wins over a same-cycle poll clear
    if (i_serial_poll) begin
      next_cur.poll_byte = {cur.status_summary_byte[7], cur.request_service_flag,
        cur.status_summary_byte[5:0]};
      next_cur.request_service_flag = 1'b0;
    end
    if (summary_any && !cur.master_summary_flag) begin
      next_cur.request_service_flag = 1'b1;
    end
    next_cur.load = i_sre_query | i_stb_query;
    if (i_stb_query) begin
      next_cur.value = live;
    end else if (i_sre_query) begin
      next_cur.value = cur.service_request_enable_mask;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cur <= '{service_request_enable_mask: ssr_pkg::SRE_RESET, status_summary_byte: ssr_pkg::STB_RESET,
        poll_byte: ssr_pkg::STB_RESET, master_summary_flag: 1'b0, request_service_flag: 1'b0,
        load: 1'b0, value: 8'h00};
    end else begin
      cur <= next_cur;
    end
  end

  assign fmt_bus.load = cur.load;
  assign fmt_bus.value = cur.value;
  assign fmt_bus.talk = i_talk_addressed;
  assign fmt_bus.take = i_byte_taken;
  assign o_status_byte = cur.status_summary_byte;
  assign o_poll_byte = cur.poll_byte;
  assign o_sre_mask = cur.service_request_enable_mask;
  assign o_srq = cur.request_service_flag;
  assign o_talk_data = fmt_bus.data;
  assign o_talk_valid = fmt_bus.valid;
endmodule

// File: testbench/ssr_status_properties.sv
// port assertions for the status block
// assumes a bind into ssr_status_top, one clock
`timescale 1ns/10ps
module ssr_status_properties (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_error_queue_nonempty,
  input wire logic i_questionable_summary,
  input wire logic i_output_queue_nonempty,
  input wire logic i_standard_event_summary,
  input wire logic i_operation_event_summary,
  input wire logic i_sre_write,
  input wire logic [7:0] i_sre_data,
  input wire logic i_talk_addressed,
  input wire logic i_serial_poll,
  input wire logic [7:0] o_status_byte,
  input wire logic [7:0] o_poll_byte,
  input wire logic [7:0] o_sre_mask,
  input wire logic o_srq,
  input wire logic o_talk_valid
);
  logic [7:0] src_q;
  // sources as seen one edge back, since the status byte is registered
  always_ff @(posedge i_core_clk) src_q <= {i_operation_event_summary, 1'b0, i_standard_event_summary,
    i_output_queue_nonempty, i_questionable_summary, i_error_queue_nonempty, 2'h0};
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_low; o_status_byte[1:0] == 2'h0; endproperty
  a_low: assert property (p_low) else $error("unused bits set");
  property p_src; !$past(i_rst) |-> (o_status_byte & 8'hAC) == (src_q & 8'hAC); endproperty
  a_src: assert property (p_src) else $error("summary bit not following source");
  property p_msg; !$past(i_rst) && src_q[4] |-> o_status_byte[4]; endproperty
  a_msg: assert property (p_msg) else $error("message bit low");
  property p_master; !$past(i_rst) && $stable(o_sre_mask) |->
    o_status_byte[6] == |(o_status_byte & o_sre_mask & 8'hBF);
  endproperty
  a_master: assert property (p_master) else $error("master summary wrong");
  property p_srq; $rose(o_status_byte[6]) |-> o_srq; endproperty
  a_srq: assert property (p_srq) else $error("no service request");
  property p_poll; !$past(i_rst) && $past(i_serial_poll) |-> o_srq == $rose(o_status_byte[6]) &&
    o_poll_byte == {$past(o_status_byte[7]), $past(o_srq), $past(o_status_byte[5:0])}; endproperty
  a_poll: assert property (p_poll) else $error("poll byte wrong");
  property p_msk; !$past(i_rst) |-> o_sre_mask == ($past(i_sre_write) ? $past(i_sre_data) & 8'hBC : $past(o_sre_mask));
  endproperty
  a_msk: assert property (p_msk) else $error("mask write wrong");
  property p_tlk; !$past(i_talk_addressed) |-> !o_talk_valid; endproperty
  a_tlk: assert property (p_tlk) else $error("talk without address");
  c_srq: cover property ($rose(o_srq));
  c_poll: cover property (i_serial_poll && o_srq);
  c_talk: cover property ($fell(o_talk_valid));
endmodule
bind ssr_status_top ssr_status_properties u_props (.*);

// File: testbench/ssr_ctl_model.sv
// bus controller model: talk addressing and byte acceptance
// assumes the answer handshake of the status block
`timescale 1ns/10ps
module ssr_ctl_model (
  input wire logic i_core_clk,
  input wire logic i_listen,
  input wire logic i_talk_valid,
  input wire logic [7:0] i_talk_data,
  output logic o_talk_addressed = 1'b0,
  output logic o_byte_taken = 1'b0
);
  logic [7:0] rx[$];
  logic lq = 1'b0;
  // listen sampled on the rising edge to stay clear of the bench's falling edge
  always @(posedge i_core_clk) begin
    lq <= i_listen;
    if (o_byte_taken && i_talk_valid) rx.push_back(i_talk_data);
  end
  // random stalls so both prompt and slow acceptance occur
  always @(negedge i_core_clk) begin
    o_talk_addressed <= lq;
    o_byte_taken <= lq && i_talk_valid && ($urandom % 2 == 0);
  end
endmodule

// File: testbench/ssr_status_top_tb.sv
// bench for the status block: random sources, mask writes, queries and polls
// assumes rtl files and the controller model compiled first
`timescale 1ns/10ps
module ssr_status_top_tb;
  logic i_core_clk, i_rst, listen, wr_en, sre_q, stb_q, poll, srq, tvalid, talk, taken;
  logic [4:0] src;
  logic [7:0] wdata, stb, pbyte, mask, tdata;
  int miscompares, samples_checked, mask_m, srq_m, master_p, e;
  ssr_status_top u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_error_queue_nonempty(src[0]),
    .i_questionable_summary(src[1]), .i_output_queue_nonempty(src[2]), .i_standard_event_summary(src[3]),
    .i_operation_event_summary(src[4]), .i_sre_write(wr_en), .i_sre_data(wdata), .i_sre_query(sre_q),
    .i_stb_query(stb_q), .i_talk_addressed(talk), .i_byte_taken(taken), .i_serial_poll(poll),
    .o_status_byte(stb), .o_poll_byte(pbyte), .o_sre_mask(mask), .o_srq(srq), .o_talk_data(tdata),
    .o_talk_valid(tvalid));
  ssr_ctl_model u_ctl (.i_core_clk(i_core_clk), .i_listen(listen), .i_talk_valid(tvalid),
    .i_talk_data(tdata), .o_talk_addressed(talk), .o_byte_taken(taken));
  function automatic int stb_m(int s);
    int b;
    b = s[4] << 7 | s[3] << 5 | s[2] << 4 | s[1] << 3 | s[0] << 2;
    return b | ((b & mask_m) ? 64 : 0);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // talk held off first so an early answer would show
  task automatic ask(input logic is_stb, input int v);
    string s;
    s = $sformatf("%0d\n", v);
    u_ctl.rx.delete();
    stb_q = is_stb;
    // a status query raises both strobes: the status byte must win
    sre_q = 1;
    tick(1);
    stb_q = 0;
    sre_q = 0;
    tick(4);
    chk(tvalid, 0);
    chk(stb[4], 1);
    listen = 1;
    for (int n = 0; n < 99 && u_ctl.rx.size() < s.len(); n++) tick(1);
    if (u_ctl.rx.size() < s.len()) begin
      miscompares++;
      summarize();
    end
    for (int i = 0; i < s.len(); i++) chk(u_ctl.rx[i], s[i]);
    listen = 0;
    tick(3);
  endtask
  initial begin
    i_core_clk = 0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  initial begin
    {i_rst, listen, wr_en, sre_q, stb_q, poll, src, wdata} = {6'h20, 5'h00, 8'h00};
    e = $urandom(32'h1FCB9E9F);
    tick(8);
    i_rst = 0;
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) begin
        src = 0;
        tick(1);
        wr_en = 1;
        wdata = i ? 8'($urandom) : 8'hFF;
        tick(1);
        wr_en = 0;
        mask_m = wdata & 8'hBC;
        chk(mask, mask_m);
        if (i == 0) ask(0, 188);
        poll = 1;
        tick(1);
        poll = 0;
        master_p = 0;
      end
      src = 5'($urandom);
      tick(1);
      e = stb_m(src);
      srq_m = srq_m | (e[6] & !master_p);
      chk(stb, e);
      chk(srq, srq_m);
      poll = 1;
      tick(1);
      poll = 0;
      chk(pbyte, (e & 8'hBF) | (srq_m << 6));
      srq_m = 0;
      chk(srq, 0);
      master_p = e[6];
    end
    // poll in the same cycle as a rising summary: the new request survives
    src = 5'h1F;
    poll = 1;
    tick(1);
    poll = 0;
    e = stb_m(src);
    chk(srq, e[6] & !master_p);
    e = stb_m(src);
    ask(1, e);
    chk(stb & 8'hBF, e & 8'hBF);
    summarize();
  end
endmodule
